// File: src/csr_core_state.sv
/*
  Architectural state registers of an 8-bit core: instruction pointer with its
  start address, primary operand register, multiply/divide register and the
  ALU status word. Software reaches all but the pointer over a plain strobe port.
  Assumes an instruction decoder drives the ALU and pointer controls on clk.
*/
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none

// Contract
// - 16-bit pointer resets to zero
// - Secondary vector loads pointer when enabled
// - Pointer not in register address space
// - Operand register feeds ALU, takes result
// - Muldiv holds mul/div results, else storage
// - Status word resets zero, bit0 read-only
// - Status captures arithmetic result flags
// - Bit7 carry or borrow
// - Bit6 half carry out of nibble
// - Bank select maps working register base
// - Bit2 signed overflow
// - Bit0 parity of operand register
module csr_core_state
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Register port
  input  wire logic       [2:0] reg_addr,
  input  wire logic       [7:0] reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic            [7:0] reg_rdata,
  // Decoder controls
  input  wire csr_pkg::csr_op_t alu_op,
  input  wire logic       [7:0] alu_operand,
  input  wire logic             ip_advance,
  input  wire logic             ip_load,
  input  wire logic      [15:0] ip_target,
  // State outputs
  output logic           [15:0] instruction_pointer,
  output logic            [7:0] primary_operand_reg,
  output logic            [7:0] muldiv_reg,
  output logic            [7:0] alu_status_word,
  output logic            [7:0] bank_base
);

  logic [7:0] vector_cfg;
  logic [7:0] next_acc;
  logic [7:0] next_muldiv;
  logic [7:0] next_status;
  logic [7:0] next_vector_cfg;
  logic [7:0] next_rdata;
  logic [7:0] next_bank_base;
  logic [15:0] next_ip;
  logic [15:0] start_address;
  logic [7:0] alu_acc;
  logic [7:0] alu_md;
  logic       alu_cy;
  logic       alu_ac;
  logic       alu_ov;
  logic       arith_op;
  logic       flag_op;
  logic       wr_status;
  logic       wr_acc;
  logic       wr_md;
  logic       wr_vec;
  logic       parity;
  logic [1:0] bank_select;
  logic       start_pending;

  csr_alu u_alu
  (
    .acc            (primary_operand_reg),
    .operand        (alu_operand),
    .muldiv         (muldiv_reg),
    .carry_in       (alu_status_word[csr_pkg::BIT_CARRY]),
    .op             (alu_op),
    .acc_result     (alu_acc),
    .muldiv_result  (alu_md),
    .carry_out      (alu_cy),
    .half_carry_out (alu_ac),
    .overflow_out   (alu_ov)
  );

  // Write and operation decode
  assign wr_status = reg_wr && (reg_addr == csr_pkg::OFF_ALU_STATUS_WORD);
  assign wr_acc    = reg_wr && (reg_addr == csr_pkg::OFF_PRIMARY_OPERAND);
  assign wr_md     = reg_wr && (reg_addr == csr_pkg::OFF_MULDIV_REG);
  assign wr_vec    = reg_wr && (reg_addr == csr_pkg::OFF_VECTOR_CFG);
  assign arith_op  = (alu_op != csr_pkg::CSR_OP_NONE);
  assign flag_op   = (alu_op == csr_pkg::CSR_OP_ADD) || (alu_op == csr_pkg::CSR_OP_ADDC) ||
                     (alu_op == csr_pkg::CSR_OP_SUBB);

  // Operand register path
  // A decoder operation wins over a software write in the same cycle
  assign next_acc = arith_op ? alu_acc : (wr_acc ? reg_wdata : primary_operand_reg);

  assign next_muldiv = ((alu_op == csr_pkg::CSR_OP_MUL) || (alu_op == csr_pkg::CSR_OP_DIV)) ? alu_md :
                       (wr_md ? reg_wdata : muldiv_reg);

  // Parity of next operand
  // Parity follows the value the operand register is about to hold
  assign parity = ^next_acc;

  always_comb
  begin
    next_status = alu_status_word;
    if (wr_status)
    begin
      next_status = reg_wdata & csr_pkg::STATUS_WR_MASK;
    end
    if (arith_op)
    begin
      next_status[csr_pkg::BIT_OVERFLOW] = alu_ov;
      if (flag_op)
      begin
        next_status[csr_pkg::BIT_CARRY]      = alu_cy;
        next_status[csr_pkg::BIT_HALF_CARRY] = alu_ac;
      end
      else
      begin
        next_status[csr_pkg::BIT_CARRY] = 1'b0;
      end
    end
    next_status[csr_pkg::BIT_PARITY] = parity;
  end

  assign bank_select    = next_status[csr_pkg::BIT_BANK_HI:csr_pkg::BIT_BANK_LO];
  assign next_bank_base = {6'h00, bank_select} * csr_pkg::BANK_STRIDE;

  assign next_vector_cfg = wr_vec ? reg_wdata : vector_cfg;

  assign start_address = vector_cfg[csr_pkg::BIT_VEC_ENABLE] ?
                         (16'(vector_cfg[3:0]) << csr_pkg::VEC_ADR_SHIFT) : csr_pkg::RST_POINTER;

  // Pointer sequencing
  // The start address is taken one cycle after reset so the vector setting applies
  assign next_ip = start_pending ? start_address :
                   ip_load       ? ip_target :
                   ip_advance    ? instruction_pointer + 16'h0001 : instruction_pointer;

  // Pointer kept off the register port
  // Offsets 3 and 4 are left unmapped and read as zero
  always_comb
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      csr_pkg::OFF_ALU_STATUS_WORD: next_rdata = alu_status_word;
      csr_pkg::OFF_PRIMARY_OPERAND: next_rdata = primary_operand_reg;
      csr_pkg::OFF_MULDIV_REG:      next_rdata = muldiv_reg;
      csr_pkg::OFF_VECTOR_CFG:      next_rdata = vector_cfg;
      default:                      next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      instruction_pointer <= csr_pkg::RST_POINTER;
      start_pending       <= 1'b1;
    end
    else
    begin
      instruction_pointer <= next_ip;
      start_pending       <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      primary_operand_reg <= csr_pkg::RST_BYTE;
      muldiv_reg          <= csr_pkg::RST_BYTE;
      alu_status_word     <= csr_pkg::RST_STATUS_WORD;
      bank_base           <= csr_pkg::RST_BYTE;
    end
    else
    begin
      primary_operand_reg <= next_acc;
      muldiv_reg          <= next_muldiv;
      alu_status_word     <= next_status;
      bank_base           <= next_bank_base;
    end
  end

  // Vector setting survives reset, as an option byte would
  always_ff @(posedge clk)
  begin
    vector_cfg <= next_vector_cfg;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      reg_rdata <= csr_pkg::RST_BYTE;
    end
    else
    begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end
  end

  // Assertions

  ip_reset_a: assert property (@(posedge clk) !rstn |=> instruction_pointer == csr_pkg::RST_POINTER)
    else $error("pointer not zero after reset");

  ip_vector_a: assert property (@(posedge clk) disable iff (!rstn)
    start_pending |=> instruction_pointer == $past(start_address))
    else $error("pointer missed start address");

  ip_load_a: assert property (@(posedge clk) disable iff (!rstn)
    !start_pending && ip_load |=> instruction_pointer == $past(ip_target))
    else $error("pointer missed load target");

  ip_step_a: assert property (@(posedge clk) disable iff (!rstn)
    !start_pending && !ip_load && ip_advance |=>
    instruction_pointer == 16'($past(instruction_pointer) + 16'h0001))
    else $error("pointer missed increment");

  ip_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !start_pending && !ip_load && !ip_advance |=> $stable(instruction_pointer))
    else $error("pointer moved while idle");

  status_reset_a: assert property (@(posedge clk) !rstn |=> alu_status_word == csr_pkg::RST_STATUS_WORD)
    else $error("status word not cleared by reset");

  status_read_a: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && (reg_addr == csr_pkg::OFF_ALU_STATUS_WORD) |=> reg_rdata == $past(alu_status_word))
    else $error("status word read wrong");

  parity_track_a: assert property (@(posedge clk) disable iff (!rstn)
    alu_status_word[csr_pkg::BIT_PARITY] == ^primary_operand_reg)
    else $error("parity bit wrong");

  carry_add_a: assert property (@(posedge clk) disable iff (!rstn)
    alu_op == csr_pkg::CSR_OP_ADD |=> alu_status_word[csr_pkg::BIT_CARRY] ==
    (({1'b0, $past(primary_operand_reg)} + {1'b0, $past(alu_operand)}) > 9'h0ff))
    else $error("carry flag wrong after add");

  borrow_sub_a: assert property (@(posedge clk) disable iff (!rstn)
    alu_op == csr_pkg::CSR_OP_SUBB |=> alu_status_word[csr_pkg::BIT_CARRY] ==
    ({1'b0, $past(primary_operand_reg)} <
     ({1'b0, $past(alu_operand)} + {8'h00, $past(alu_status_word[csr_pkg::BIT_CARRY])})))
    else $error("borrow flag wrong after subtract");

  half_carry_a: assert property (@(posedge clk) disable iff (!rstn)
    alu_op == csr_pkg::CSR_OP_ADD |=> alu_status_word[csr_pkg::BIT_HALF_CARRY] ==
    (({1'b0, $past(primary_operand_reg[3:0])} + {1'b0, $past(alu_operand[3:0])}) > 5'h0f))
    else $error("half carry wrong after add");

  half_borrow_a: assert property (@(posedge clk) disable iff (!rstn)
    alu_op == csr_pkg::CSR_OP_SUBB |=> alu_status_word[csr_pkg::BIT_HALF_CARRY] ==
    ({1'b0, $past(primary_operand_reg[3:0])} <
     ({1'b0, $past(alu_operand[3:0])} + {4'h0, $past(alu_status_word[csr_pkg::BIT_CARRY])})))
    else $error("half borrow wrong after subtract");

  overflow_add_a: assert property (@(posedge clk) disable iff (!rstn)
    alu_op == csr_pkg::CSR_OP_ADD |=> alu_status_word[csr_pkg::BIT_OVERFLOW] ==
    (($past(primary_operand_reg[7]) == $past(alu_operand[7])) &&
     (primary_operand_reg[7] != $past(primary_operand_reg[7]))))
    else $error("overflow flag wrong after add");

  acc_result_a: assert property (@(posedge clk) disable iff (!rstn)
    alu_op == csr_pkg::CSR_OP_ADD |=>
    primary_operand_reg == 8'($past(primary_operand_reg) + $past(alu_operand)))
    else $error("operand register missed sum");

  mul_result_a: assert property (@(posedge clk) disable iff (!rstn)
    alu_op == csr_pkg::CSR_OP_MUL |=>
    {muldiv_reg, primary_operand_reg} == {8'h00, $past(primary_operand_reg)} * {8'h00, $past(muldiv_reg)})
    else $error("product not in register pair");

  mul_flags_a: assert property (@(posedge clk) disable iff (!rstn)
    alu_op == csr_pkg::CSR_OP_MUL |=>
    !alu_status_word[csr_pkg::BIT_CARRY] && (alu_status_word[csr_pkg::BIT_OVERFLOW] == (muldiv_reg != 8'h00)))
    else $error("flags wrong after multiply");

  div_result_a: assert property (@(posedge clk) disable iff (!rstn)
    alu_op == csr_pkg::CSR_OP_DIV && muldiv_reg != 8'h00 |=>
    primary_operand_reg == $past(primary_operand_reg) / $past(muldiv_reg) &&
    muldiv_reg == $past(primary_operand_reg) % $past(muldiv_reg))
    else $error("quotient or remainder wrong");

  div_zero_a: assert property (@(posedge clk) disable iff (!rstn)
    alu_op == csr_pkg::CSR_OP_DIV && muldiv_reg == 8'h00 |=>
    alu_status_word[csr_pkg::BIT_OVERFLOW] && $stable(primary_operand_reg))
    else $error("divide by zero not flagged");

  user_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    wr_status && !arith_op |=> alu_status_word[7:1] == $past(reg_wdata[7:1]))
    else $error("status write not stored");

  user_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !wr_status |=> $stable(alu_status_word[csr_pkg::BIT_USER_FLAG]))
    else $error("user flag changed without write");

  bank_map_a: assert property (@(posedge clk) disable iff (!rstn)
    ##1 bank_base == {3'h0, alu_status_word[csr_pkg::BIT_BANK_HI:csr_pkg::BIT_BANK_LO], 3'h0})
    else $error("bank base mismatch");

  bank_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !wr_status |=> $stable(bank_base))
    else $error("bank base changed without write");

  ptr_hidden_a: assert property (@(posedge clk) disable iff (!rstn)
    reg_rd && (reg_addr == csr_pkg::OFF_PTR_LOW || reg_addr == csr_pkg::OFF_PTR_HIGH) |=> reg_rdata == 8'h00)
    else $error("pointer visible on register port");

  rdata_idle_a: assert property (@(posedge clk) disable iff (!rstn)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read strobe");

  add_seen_c: cover property (@(posedge clk) disable iff (!rstn) alu_op == csr_pkg::CSR_OP_ADD ##1 alu_status_word[7]);
  div_zero_c: cover property (@(posedge clk) disable iff (!rstn) alu_op == csr_pkg::CSR_OP_DIV && muldiv_reg == 8'h00);
  mul_seen_c: cover property (@(posedge clk) disable iff (!rstn) alu_op == csr_pkg::CSR_OP_MUL);
  vec_start_c: cover property (@(posedge clk) start_pending && vector_cfg[7]);
  bank_three_c: cover property (@(posedge clk) disable iff (!rstn) bank_base == 8'h18);

endmodule : csr_core_state

`default_nettype wire

// File: src/csr_pkg.sv
/*
  Constants of the core state register block: register offsets, status word
  field positions, reset values and ALU operation codes.
  Assumes a single 100 MHz core clock and a synchronous active-low reset.
*/
package csr_pkg;

  // Register port offsets
  localparam logic [2:0] OFF_ALU_STATUS_WORD = 3'h0;
  localparam logic [2:0] OFF_PRIMARY_OPERAND = 3'h1;
  localparam logic [2:0] OFF_MULDIV_REG      = 3'h2;
  localparam logic [2:0] OFF_PTR_LOW         = 3'h3;
  localparam logic [2:0] OFF_PTR_HIGH        = 3'h4;
  localparam logic [2:0] OFF_VECTOR_CFG      = 3'h5;

  // Status word field positions
  localparam int unsigned BIT_CARRY      = 7;
  localparam int unsigned BIT_HALF_CARRY = 6;
  localparam int unsigned BIT_USER_FLAG  = 5;
  localparam int unsigned BIT_BANK_HI    = 4;
  localparam int unsigned BIT_BANK_LO    = 3;
  localparam int unsigned BIT_OVERFLOW   = 2;
  localparam int unsigned BIT_USER_FLAG1 = 1;
  localparam int unsigned BIT_PARITY     = 0;

  // Secondary vector configuration fields
  localparam int unsigned BIT_VEC_ENABLE = 7;
  localparam int unsigned VEC_ADR_SHIFT  = 9;

  // Reset values and status write mask
  localparam logic [7:0]  RST_STATUS_WORD  = 8'h00;
  localparam logic [7:0]  RST_BYTE         = 8'h00;
  localparam logic [15:0] RST_POINTER      = 16'h0000;
  localparam logic [7:0]  STATUS_WR_MASK   = 8'hfe;

  // Bank base addresses in internal RAM
  localparam logic [7:0] BANK_STRIDE = 8'h08;

  typedef enum logic [2:0]
  {
    CSR_OP_NONE = 3'b000,
    CSR_OP_ADD  = 3'b001,
    CSR_OP_ADDC = 3'b010,
    CSR_OP_SUBB = 3'b011,
    CSR_OP_MUL  = 3'b100,
    CSR_OP_DIV  = 3'b101
  } csr_op_t;

endpackage : csr_pkg

// File: src/csr_alu.sv
/*
  Combinational arithmetic unit of the core state block: add, add with carry,
  subtract with borrow, multiply and divide on 8-bit operands with flags.
  Assumes the caller registers every result.
*/
`timescale 1ns/1ns
`default_nettype none

module csr_alu
(
  // Operands
  input  wire logic           [7:0] acc,
  input  wire logic           [7:0] operand,
  input  wire logic           [7:0] muldiv,
  input  wire logic                 carry_in,
  input  wire csr_pkg::csr_op_t     op,
  // Results
  output logic                [7:0] acc_result,
  output logic                [7:0] muldiv_result,
  output logic                      carry_out,
  output logic                      half_carry_out,
  output logic                      overflow_out
);

  logic [8:0] sum_full;
  logic [4:0] sum_low;
  logic       cin;
  logic [7:0] opb;
  logic       is_sub;
  logic [15:0] product;
  logic        div_zero;

  assign is_sub   = (op == csr_pkg::CSR_OP_SUBB);
  assign cin      = (op == csr_pkg::CSR_OP_ADD) ? 1'b0 : carry_in;
  // Subtraction with borrow as addition of the inverted operand
  assign opb      = is_sub ? ~operand : operand;
  assign sum_full = {1'b0, acc} + {1'b0, opb} + {8'h00, is_sub ^ cin};
  assign sum_low  = {1'b0, acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, is_sub ^ cin};
  assign product  = {8'h00, acc} * {8'h00, muldiv};
  assign div_zero = (muldiv == 8'h00);

  always_comb
  begin
    acc_result     = acc;
    muldiv_result  = muldiv;
    carry_out      = 1'b0;
    half_carry_out = 1'b0;
    overflow_out   = 1'b0;
    case (op)
      csr_pkg::CSR_OP_ADD, csr_pkg::CSR_OP_ADDC, csr_pkg::CSR_OP_SUBB:
      begin
        acc_result     = sum_full[7:0];
        carry_out      = sum_full[8] ^ is_sub;
        half_carry_out = sum_low[4] ^ is_sub;
        overflow_out   = (acc[7] == opb[7]) && (sum_full[7] != acc[7]);
      end
      csr_pkg::CSR_OP_MUL:
      begin
        acc_result    = product[7:0];
        muldiv_result = product[15:8];
        overflow_out  = (product[15:8] != 8'h00);
      end
      csr_pkg::CSR_OP_DIV:
      begin
        // A zero divisor leaves both registers unchanged and sets overflow
        acc_result    = div_zero ? acc : acc / muldiv;
        muldiv_result = div_zero ? muldiv : acc % muldiv;
        overflow_out  = div_zero;
      end
      default:
      begin
        acc_result = acc;
      end
    endcase
  end

endmodule : csr_alu

`default_nettype wire

// File: sim/csr_core_state_tb.sv
/*
  Self-checking bench for the core state register block: reset values,
  register port, ALU flags, multiply/divide and the pointer start address.
  Assumes the block is driven only through its ports on a 100 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none

`define CHK(got, exp) begin compares += 1; if ((got) !== (exp)) begin error_cnt += 1; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end

module csr_core_state_tb;
  logic             clk         = 1'b0;
  logic             rstn        = 1'b0;
  logic       [2:0] reg_addr    = 3'h0;
  logic       [7:0] reg_wdata   = 8'h00;
  logic             reg_wr      = 1'b0;
  logic             reg_rd      = 1'b0;
  csr_pkg::csr_op_t alu_op      = csr_pkg::CSR_OP_NONE;
  logic       [7:0] alu_operand = 8'h00;
  logic             ip_advance  = 1'b0;
  logic             ip_load     = 1'b0;
  logic      [15:0] ip_target   = 16'h0000;
  logic       [7:0] reg_rdata;
  logic      [15:0] instruction_pointer;
  logic       [7:0] primary_operand_reg;
  logic       [7:0] muldiv_reg;
  logic       [7:0] alu_status_word;
  logic       [7:0] bank_base;
  logic       [7:0] rv;
  int               error_cnt   = 0;
  int               compares    = 0;

  csr_core_state dut
  (
    .clk                 (clk),
    .rstn                (rstn),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .alu_op              (alu_op),
    .alu_operand         (alu_operand),
    .ip_advance          (ip_advance),
    .ip_load             (ip_load),
    .ip_target           (ip_target),
    .instruction_pointer (instruction_pointer),
    .primary_operand_reg (primary_operand_reg),
    .muldiv_reg          (muldiv_reg),
    .alu_status_word     (alu_status_word),
    .bank_base           (bank_base)
  );

  always #5 clk = ~clk;

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  // Read data are valid only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic alu(input csr_pkg::csr_op_t op, input logic [7:0] y);
    @(posedge clk);
    alu_op      <= op;
    alu_operand <= y;
    @(posedge clk);
    alu_op      <= csr_pkg::CSR_OP_NONE;
    #1;
  endtask : alu

  // One reset edge, then the first edge after release loads the start address
  task automatic do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
  endtask : do_reset

  task automatic t_reset_vals;
    wr(csr_pkg::OFF_VECTOR_CFG, 8'h00);
    wr(csr_pkg::OFF_PRIMARY_OPERAND, 8'h5a);
    do_reset();
    `CHK(instruction_pointer, 16'h0000)
    `CHK(alu_status_word, 8'h00)
    `CHK(primary_operand_reg, 8'h00)
    `CHK(muldiv_reg, 8'h00)
    rd(csr_pkg::OFF_ALU_STATUS_WORD, rv);
    `CHK(rv, 8'h00)
  endtask : t_reset_vals

  task automatic t_regs;
    wr(csr_pkg::OFF_PRIMARY_OPERAND, 8'h07);
    `CHK(alu_status_word[0], 1'b1)
    wr(csr_pkg::OFF_PRIMARY_OPERAND, 8'h03);
    `CHK(alu_status_word[0], 1'b0)
    wr(csr_pkg::OFF_ALU_STATUS_WORD, 8'hff);
    rd(csr_pkg::OFF_ALU_STATUS_WORD, rv);
    `CHK(rv, 8'hfe)
    `CHK(rv[5], 1'b1)
    wr(csr_pkg::OFF_MULDIV_REG, 8'hc3);
    rd(csr_pkg::OFF_MULDIV_REG, rv);
    `CHK(rv, 8'hc3)
    @(posedge clk);
    #1;
    `CHK(reg_rdata, 8'h00)
    rd(csr_pkg::OFF_PRIMARY_OPERAND, rv);
    `CHK(rv, 8'h03)
    for (int b = 0; b < 4; b++)
    begin
      wr(csr_pkg::OFF_ALU_STATUS_WORD, {3'h0, 2'(b), 3'h0});
      @(posedge clk);
      #1;
      `CHK(bank_base, 8'(b * 8))
      `CHK(alu_status_word[4:3], 2'(b))
    end
  endtask : t_regs

  task automatic t_unmapped;
    @(posedge clk);
    ip_load   <= 1'b1;
    ip_target <= 16'ha5c3;
    @(posedge clk);
    ip_load   <= 1'b0;
    for (int a = 3; a < 8; a++)
    begin
      if (a != 5)
      begin
        wr(3'(a), 8'h11);
        rd(3'(a), rv);
        `CHK(rv, 8'h00)
      end
    end
    `CHK(instruction_pointer, 16'ha5c3)
  endtask : t_unmapped

  task automatic t_add;
    wr(csr_pkg::OFF_ALU_STATUS_WORD, 8'h00);
    wr(csr_pkg::OFF_PRIMARY_OPERAND, 8'h7f);
    alu(csr_pkg::CSR_OP_ADD, 8'h01);
    `CHK(primary_operand_reg, 8'h80)
    `CHK(alu_status_word, 8'h45)
    alu(csr_pkg::CSR_OP_ADD, 8'h01);
    `CHK(alu_status_word, 8'h00)
    wr(csr_pkg::OFF_PRIMARY_OPERAND, 8'hff);
    alu(csr_pkg::CSR_OP_ADD, 8'h01);
    `CHK(alu_status_word, 8'hc0)
    alu(csr_pkg::CSR_OP_ADDC, 8'h00);
    `CHK(primary_operand_reg, 8'h01)
    `CHK(alu_status_word, 8'h01)
    alu(csr_pkg::CSR_OP_SUBB, 8'h02);
    `CHK(primary_operand_reg, 8'hff)
    `CHK(alu_status_word, 8'hc0)
  endtask : t_add

  task automatic t_muldiv;
    wr(csr_pkg::OFF_PRIMARY_OPERAND, 8'h20);
    wr(csr_pkg::OFF_MULDIV_REG, 8'h10);
    alu(csr_pkg::CSR_OP_MUL, 8'h00);
    `CHK({muldiv_reg, primary_operand_reg}, 16'h0200)
    `CHK({alu_status_word[7], alu_status_word[2]}, 2'b01)
    wr(csr_pkg::OFF_PRIMARY_OPERAND, 8'h25);
    wr(csr_pkg::OFF_MULDIV_REG, 8'h07);
    alu(csr_pkg::CSR_OP_DIV, 8'h00);
    `CHK({muldiv_reg, primary_operand_reg}, 16'h0205)
    `CHK({alu_status_word[7], alu_status_word[2]}, 2'b00)
    wr(csr_pkg::OFF_MULDIV_REG, 8'h00);
    alu(csr_pkg::CSR_OP_DIV, 8'h00);
    `CHK(primary_operand_reg, 8'h05)
    `CHK(alu_status_word[2], 1'b1)
  endtask : t_muldiv

  task automatic t_pointer;
    do_reset();
    @(posedge clk);
    ip_advance <= 1'b1;
    repeat (3) @(posedge clk);
    ip_load    <= 1'b1;
    ip_target  <= 16'hfffe;
    @(posedge clk);
    ip_load    <= 1'b0;
    // Two more steps: fffe to ffff, then wrap to zero
    repeat (2) @(posedge clk);
    ip_advance <= 1'b0;
    @(posedge clk);
    #1;
    // Load wins over advance, then the count wraps at 16 bits
    `CHK(instruction_pointer, 16'h0000)
    wr(csr_pkg::OFF_VECTOR_CFG, 8'h84);
    do_reset();
    `CHK(instruction_pointer, 16'h0800)
    rd(csr_pkg::OFF_VECTOR_CFG, rv);
    `CHK(rv, 8'h84)
    wr(csr_pkg::OFF_VECTOR_CFG, 8'h0f);
    do_reset();
    `CHK(instruction_pointer, 16'h0000)
  endtask : t_pointer

  task automatic conclude;
    $display("Checks: %0d, mismatches: %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (5) @(posedge clk);
    // Vector setting has no reset; define it while reset is held
    wr(csr_pkg::OFF_VECTOR_CFG, 8'h00);
    @(posedge clk);
    rstn <= 1'b1;
    t_reset_vals();
    t_regs();
    t_unmapped();
    t_add();
    t_muldiv();
    t_pointer();
    conclude();
  end

  // The scenarios need well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clk);
    error_cnt += 1;
    conclude();
  end
endmodule : csr_core_state_tb

`undef CHK
`default_nettype wire
